//--- logic/dua_pkg.sv
package dua_pkg;

  // ----------------------------------------------------------------
  // channel count and host address map
  // ----------------------------------------------------------------
  localparam int         NUM_CH    = 2;
  localparam logic [2:0] A_DATA    = 3'h0;  // receive/transmit holding
  localparam logic [2:0] A_IENA    = 3'h1;  // interrupt_enable
  localparam logic [2:0] A_ISTS    = 3'h2;  // interrupt_status / fifo_control
  localparam logic [2:0] A_LCTL    = 3'h3;  // line_control
  localparam logic [2:0] A_MCTL    = 3'h4;  // modem_control
  localparam logic [2:0] A_LSTS    = 3'h5;  // line_status
  localparam logic [2:0] A_MSTS    = 3'h6;  // modem_status
  localparam logic [2:0] A_SCR     = 3'h7;  // scratch_pad
  localparam logic [2:0] A_DIV_LO  = 3'h0;  // divisor_low / revision_code
  localparam logic [2:0] A_DIV_HI  = 3'h1;  // divisor_high / identification_code
  localparam logic [2:0] A_DIV_FR  = 3'h2;  // divisor_fraction
  localparam logic [2:0] A_EFUNC   = 3'h2;  // enhanced_function
  localparam logic [2:0] A_RES1    = 3'h4;  // resume_char_1
  localparam logic [2:0] A_RES2    = 3'h5;  // resume_char_2
  localparam logic [2:0] A_PAU1    = 3'h6;  // pause_char_1
  localparam logic [2:0] A_PAU2    = 3'h7;  // pause_char_2

  // ----------------------------------------------------------------
  // field positions, masks and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ENH_PAGE  = 8'hbf;
  localparam logic [7:0] DIV_ZERO  = 8'h00;
  localparam int         LC_DIV    = 7;
  localparam int         LC_BRK    = 6;
  localparam int         LC_STOP   = 2;
  localparam int         MC_DTR    = 0;
  localparam int         MC_RTS    = 1;
  localparam int         MC_OP1    = 2;
  localparam int         MC_OP2    = 3;
  localparam int         MC_LOOP   = 4;
  localparam int         EF_ENH    = 4;
  localparam int         FC_EN     = 0;
  localparam int         FC_RXRST  = 1;
  localparam int         FC_TXRST  = 2;
  localparam logic [7:0] DLD_MASK  = 8'h3f;
  localparam logic [3:0] IS_NONE   = 4'h1;
  localparam logic [3:0] IS_LINE   = 4'h6;
  localparam logic [3:0] IS_RXD    = 4'h4;
  localparam logic [3:0] IS_TXE    = 4'h2;
  localparam logic [3:0] IS_MODEM  = 4'h0;
  localparam logic [3:0] WORD_BASE = 4'h5;  // word length code 0 = 5 bits
  localparam logic [3:0] SUB_MID   = 4'h7;  // half of the 16x bit time
  localparam logic [3:0] SUB_LAST  = 4'hf;  // end of the 16x bit time

  // ----------------------------------------------------------------
  // carriers and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       chip_select_a_n;
    logic       chip_select_b_n;
    logic       read_n;
    logic       write_n;
    logic [2:0] addr;
    logic [7:0] wdata;
  } dua_bus_req_t;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } dua_modem_in_t;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
  } dua_serial_out_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } dua_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } dua_rx_state_t;

  typedef struct packed {
    logic [7:0]      interrupt_enable, fifo_control, line_control, modem_control, scratch_pad, dll, divisor_high, divisor_fraction, enhanced_function;
    logic [7:0]      res1, res2, pau1, pau2, receive_holding;
    logic            dr, ovr, fra, brk, tick;
    logic [3:0]      mlevel, mdelta;
    logic [15:0]     bcnt;
    dua_tx_state_t   txs;
    logic [7:0]      txsh;
    logic [3:0]      txsub, txbit;
    dua_rx_state_t   rxs;
    logic [7:0]      rxsh;
    logic [3:0]      rxsub, rxbit;
    dua_serial_out_t pins;
  } dua_chan_t;

  localparam dua_chan_t CHAN_RST = '{
    default: '0,
    txs:     TX_IDLE,
    rxs:     RX_IDLE,
    pins:    '{txd: 1'b1, rts_n: 1'b1, dtr_n: 1'b1}
  };

endpackage : dua_pkg

//--- logic/dua_uart.sv
`timescale 1ns/1ps
// Summary of operation
// R01 - modem_control bit 4 set enters internal loopback, clearing it leaves it
// R02 - loopback feeds transmit shifter output into receiver; characters come back
// R03 - in loopback txd, rts_n, dtr_n held high; modem input pins ignored
// R04 - system keeps receive pin high during loopback to avoid false break
// R05 - automatic rts/cts flow control need not run during loopback
// R06 - two channels, own register sets, three address bits, chip select per channel
// R07 - address 0 with divisor bit clear reads receive_holding, writes transmit_holding
// R08 - divisor bit set, not 0xbf: addresses 0 and 1 are divisor_low and divisor_high
// R09 - address 2 is divisor_fraction with divisor bit, not 0xbf, enhanced enabled
// R10 - divisor zero in divisor page: reads give revision and identification codes
// R11 - address 1 with divisor bit clear is interrupt_enable, eight enable bits
// R12 - address 2, not 0xbf: read interrupt_status, write fifo_control
// R13 - address 3 always line_control: divisor, break, parity, stop, word length
// R14 - not 0xbf: address 5 reads line_status, address 6 reads modem_status
// R15 - line_control 0xbf opens enhanced_function and four flow characters
// R16 - enhanced bits writable and effective only with enhanced_function bit 4
// R17 - modem_control bits: dtr, rts, ir invert, int enable, loop, any, ir, prescale
// R18 - address 7 is a side-effect-free scratch_pad outside the enhanced page
// R19 - in loopback rts, dtr, aux one, aux two drive cts, dsr, ri, cd status
module dua_uart #(
  parameter int         BUF_DEPTH = 2,
  parameter logic [7:0] REV_CODE  = 8'h01,  // arbitrary value
  parameter logic [7:0] ID_CODE   = 8'h5a   // arbitrary value
) (
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  dua_pkg::dua_bus_req_t               host_req,
  output logic [7:0]                          host_rdata,
  input  wire logic [1:0]                     rx_pin,
  input  dua_pkg::dua_modem_in_t [1:0]        modem_in,
  output dua_pkg::dua_serial_out_t [1:0]      serial_out,
  output logic [1:0]                          tx_space
);
  import dua_pkg::*;

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  // the buffer pointers wrap by overflow, so depth must be a power of two
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // host strobes and read data
  // ----------------------------------------------------------------
  logic       prev_rd_n;
  logic       prev_wr_n;
  logic       next_prev_rd_n;
  logic       next_prev_wr_n;
  logic [7:0] next_rdata;
  logic [1:0] sel;
  logic [1:0] rd_go;
  logic [1:0] wr_go;
  logic [7:0] ch_rdata [NUM_CH];

  // act once per strobe, on its falling edge, so held strobes cause no repeats
  assign sel   = ~{host_req.chip_select_b_n, host_req.chip_select_a_n};  // R06
  assign rd_go = sel & {2{!host_req.read_n && prev_rd_n}};
  assign wr_go = sel & {2{!host_req.write_n && prev_wr_n}};

  // channel a wins the read bus if both selects are low
  always_comb begin
    next_prev_rd_n = host_req.read_n;
    next_prev_wr_n = host_req.write_n;
    next_rdata     = host_rdata;
    if (rd_go[0]) begin
      next_rdata = ch_rdata[0];
    end else if (rd_go[1]) begin
      next_rdata = ch_rdata[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_rd_n  <= 1'b1;
      prev_wr_n  <= 1'b1;
      host_rdata <= 8'h00;
    end else begin
      prev_rd_n  <= next_prev_rd_n;
      prev_wr_n  <= next_prev_wr_n;
      host_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // per-channel register set, buffer and serial engines
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    dua_chan_t     r;
    dua_chan_t     next_r;
    logic [7:0]    buf_mem [BUF_DEPTH];
    logic [PW-1:0] wp, rp, next_wp, next_rp;
    logic [PW:0]   cnt, next_cnt;
    logic          space, next_space;
    logic          push, pop, flush;
    logic          bvalid, bempty;
    logic          lb, enh, bf, dlab, idc, line_tx, rxin, rd, wr;
    logic [3:0]    lvl, nb, isrc;
    logic [7:0]    rv, wd;
    logic [2:0]    a;
    logic [15:0]   div;

    assign a       = host_req.addr;
    assign wd      = host_req.wdata;
    assign rd      = rd_go[ch];
    assign wr      = wr_go[ch];
    assign lb      = r.modem_control[MC_LOOP];                              // R01
    assign enh     = r.enhanced_function[EF_ENH];
    assign bf      = (r.line_control == ENH_PAGE);
    assign dlab    = r.line_control[LC_DIV] && !bf;
    assign idc     = dlab && (r.dll == DIV_ZERO) && (r.divisor_high == DIV_ZERO);
    assign nb      = WORD_BASE + {2'b00, r.line_control[1:0]};
    assign div     = {r.divisor_high, r.dll};
    assign bvalid  = (cnt != '0);
    assign bempty  = !bvalid;
    assign line_tx = r.line_control[LC_BRK] ? 1'b0 :
                     (r.txs == TX_START) ? 1'b0 :
                     (r.txs == TX_DATA) ? r.txsh[0] : 1'b1;
    // receiver listens to its own transmitter in loopback
    assign rxin    = lb ? line_tx : rx_pin[ch];                   // R02
    // status bits are cd, ri, dsr, cts; active high inside
    assign lvl     = lb ? {r.modem_control[MC_OP2], r.modem_control[MC_OP1],
                           r.modem_control[MC_DTR], r.modem_control[MC_RTS]} :        // R19
                          ~{modem_in[ch].cd_n, modem_in[ch].ri_n,
                            modem_in[ch].dsr_n, modem_in[ch].cts_n};  // R03
    assign ch_rdata[ch] = rv;

    // ---------------- read multiplexer and interrupt source code
    always_comb begin
      isrc = IS_NONE;
      if (r.interrupt_enable[2] && (r.ovr || r.fra || r.brk)) begin
        isrc = IS_LINE;
      end else if (r.interrupt_enable[0] && r.dr) begin
        isrc = IS_RXD;
      end else if (r.interrupt_enable[1] && bempty) begin
        isrc = IS_TXE;
      end else if (r.interrupt_enable[3] && (r.mdelta != 4'h0)) begin
        isrc = IS_MODEM;
      end
      rv = 8'h00;
      if (a == A_LCTL) begin
        rv = r.line_control;                                               // R13
      end else if (bf) begin                                      // R15
        if (a == A_EFUNC) begin
          rv = r.enhanced_function;
        end else if (a == A_RES1) begin
          rv = r.res1;
        end else if (a == A_RES2) begin
          rv = r.res2;
        end else if (a == A_PAU1) begin
          rv = r.pau1;
        end else if (a == A_PAU2) begin
          rv = r.pau2;
        end
      end else if (idc && a == A_DIV_LO) begin
        rv = REV_CODE;                                            // R10
      end else if (idc && a == A_DIV_HI) begin
        rv = ID_CODE;                                             // R10
      end else if (dlab && a == A_DIV_LO) begin
        rv = r.dll;                                               // R08
      end else if (dlab && a == A_DIV_HI) begin
        rv = r.divisor_high;                                               // R08
      end else if (dlab && enh && a == A_DIV_FR) begin
        rv = r.divisor_fraction & DLD_MASK;                                    // R09
      end else if (a == A_DATA) begin
        rv = r.receive_holding;                                               // R07
      end else if (a == A_IENA) begin
        rv = enh ? r.interrupt_enable : {4'h0, r.interrupt_enable[3:0]};                    // R11 R16
      end else if (a == A_ISTS) begin
        rv = {{2{r.fifo_control[FC_EN]}}, 2'b00, isrc};                    // R12
      end else if (a == A_MCTL) begin
        rv = enh ? r.modem_control : {3'b000, r.modem_control[4:0]};                  // R16
      end else if (a == A_LSTS) begin                             // R14
        rv = {r.fifo_control[FC_EN] && (r.fra || r.brk), bempty && (r.txs == TX_IDLE),
              bempty, r.brk, r.fra, 1'b0, r.ovr, r.dr};
      end else if (a == A_MSTS) begin
        rv = {r.mlevel, r.mdelta};                                // R14
      end else begin
        rv = r.scratch_pad;                                               // R18
      end
    end

    // ---------------- registers, baud tick, transmitter and receiver
    always_comb begin
      next_r = r;
      push   = 1'b0;
      flush  = 1'b0;
      pop    = 1'b0;

      // host writes; line_control is reachable on every page
      if (wr) begin
        if (a == A_LCTL) begin
          next_r.line_control = wd;                                        // R13
        end else if (bf) begin                                    // R15
          if (a == A_EFUNC) begin
            next_r.enhanced_function = wd;
          end else if (a == A_RES1) begin
            next_r.res1 = wd;
          end else if (a == A_RES2) begin
            next_r.res2 = wd;
          end else if (a == A_PAU1) begin
            next_r.pau1 = wd;
          end else if (a == A_PAU2) begin
            next_r.pau2 = wd;
          end
        end else if (dlab && a == A_DIV_LO) begin
          next_r.dll = wd;                                        // R08
        end else if (dlab && a == A_DIV_HI) begin
          next_r.divisor_high = wd;                                        // R08
        end else if (dlab && enh && a == A_DIV_FR) begin
          next_r.divisor_fraction = wd & DLD_MASK;                             // R09
        end else if (a == A_DATA) begin
          push = 1'b1;                                            // R07
        end else if (a == A_IENA) begin
          next_r.interrupt_enable[3:0] = wd[3:0];                              // R11
          if (enh) begin
            next_r.interrupt_enable[7:4] = wd[7:4];                            // R16
          end
        end else if (a == A_ISTS) begin
          next_r.fifo_control[7:6]   = wd[7:6];                            // R12
          next_r.fifo_control[3]     = wd[3];
          next_r.fifo_control[FC_EN] = wd[FC_EN];
          if (enh) begin
            next_r.fifo_control[5:4] = wd[5:4];                            // R16
          end
          flush = wd[FC_TXRST];
          if (wd[FC_RXRST]) begin
            next_r.dr  = 1'b0;
            next_r.rxs = RX_IDLE;
          end
        end else if (a == A_MCTL) begin
          next_r.modem_control[4:0] = wd[4:0];                              // R17
          if (enh) begin
            next_r.modem_control[7:5] = wd[7:5];                            // R16
          end
        end else if (a == A_SCR) begin
          next_r.scratch_pad = wd;                                        // R18
        end
      end

      // read side effects: clears first, so later sets win
      if (rd && !bf && !dlab && a == A_DATA) begin
        next_r.dr = 1'b0;
      end
      if (rd && !bf && a == A_LSTS) begin
        next_r.ovr = 1'b0;
        next_r.fra = 1'b0;
        next_r.brk = 1'b0;
      end
      if (rd && !bf && a == A_MSTS) begin
        next_r.mdelta = 4'h0;
      end

      // modem inputs: any level change sets its delta flag
      next_r.mlevel = lvl;
      next_r.mdelta = next_r.mdelta | (lvl ^ r.mlevel);           // R14

      // 16x tick; a zero divisor stops the engines
      next_r.tick = 1'b0;
      if (div != 16'h0000) begin
        if (r.bcnt >= div - 16'h0001) begin
          next_r.bcnt = 16'h0000;
          next_r.tick = 1'b1;
        end else begin
          next_r.bcnt = r.bcnt + 16'h0001;
        end
      end

      // transmitter: the bit time ends when the 16x count wraps
      if (r.tick) begin
        next_r.txsub = r.txsub + 4'h1;
      end
      case (r.txs)
        TX_IDLE: begin
          next_r.txsub = 4'h0;
          next_r.txbit = 4'h0;
          if (bvalid && !flush) begin
            pop         = 1'b1;
            next_r.txsh = buf_mem[rp];
            next_r.txs  = TX_START;
          end
        end
        TX_START: begin
          if (r.tick && r.txsub == SUB_LAST) begin
            next_r.txs = TX_DATA;
          end
        end
        TX_DATA: begin
          if (r.tick && r.txsub == SUB_LAST) begin
            next_r.txsh  = {1'b0, r.txsh[7:1]};
            next_r.txbit = r.txbit + 4'h1;
            if (r.txbit == nb - 4'h1) begin
              next_r.txbit = 4'h0;
              next_r.txs   = TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (r.tick && r.txsub == SUB_LAST) begin
            next_r.txbit = 4'h1;
            if (!r.line_control[LC_STOP] || r.txbit != 4'h0) begin
              next_r.txs = TX_IDLE;
            end
          end
        end
        default: begin
          next_r.txs = TX_IDLE;
        end
      endcase

      // receiver: start bit checked at mid-bit, data sampled a bit later
      if (r.tick) begin
        next_r.rxsub = r.rxsub + 4'h1;
      end
      case (r.rxs)
        RX_IDLE: begin
          next_r.rxsub = 4'h0;
          next_r.rxbit = 4'h0;
          if (r.tick && !rxin) begin
            next_r.rxs = RX_START;
          end
        end
        RX_START: begin
          if (r.tick && r.rxsub == SUB_MID) begin
            next_r.rxsub = 4'h0;
            next_r.rxs   = rxin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (r.tick && r.rxsub == SUB_LAST) begin
            next_r.rxsh  = {rxin, r.rxsh[7:1]};
            next_r.rxbit = r.rxbit + 4'h1;
            if (r.rxbit == nb - 4'h1) begin
              next_r.rxs = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (r.tick && r.rxsub == SUB_LAST) begin
            next_r.rxs = RX_IDLE;
            // a full holding register is kept; the newcomer is lost
            if (next_r.dr) begin
              next_r.ovr = 1'b1;
            end else begin
              next_r.receive_holding = r.rxsh >> (4'h8 - nb);
              next_r.dr  = 1'b1;
            end
            next_r.fra = next_r.fra | !rxin;
            next_r.brk = next_r.brk | (!rxin && r.rxsh == 8'h00);
          end
        end
        default: begin
          next_r.rxs = RX_IDLE;
        end
      endcase

      // pins: loopback parks every output at its idle level
      next_r.pins.txd   = lb ? 1'b1 : line_tx;                    // R03
      next_r.pins.rts_n = lb ? 1'b1 : !r.modem_control[MC_RTS];             // R03 R05 R17
      next_r.pins.dtr_n = lb ? 1'b1 : !r.modem_control[MC_DTR];             // R03 R17
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        r <= CHAN_RST;
      end else begin
        r <= next_r;
      end
    end

    // ---------------- two-entry transmit buffer
    // a write into a full buffer is refused; tx_space tells the host why
    always_comb begin
      next_wp    = wp;
      next_rp    = rp;
      next_cnt   = cnt;
      if (flush) begin
        next_wp  = '0;
        next_rp  = '0;
        next_cnt = '0;
      end else begin
        if (push && space) begin
          next_wp = wp + 1'b1;
        end
        if (pop) begin
          next_rp = rp + 1'b1;
        end
        next_cnt = cnt + {{PW{1'b0}}, push && space} - {{PW{1'b0}}, pop};
      end
      next_space = (next_cnt != BUF_DEPTH[PW:0]);
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        wp    <= '0;
        rp    <= '0;
        cnt   <= '0;
        space <= 1'b1;
      end else begin
        wp    <= next_wp;
        rp    <= next_rp;
        cnt   <= next_cnt;
        space <= next_space;
      end
    end

    // buffer storage needs no reset; only entries counted in cnt are read
    always_ff @(posedge mclk) begin
      if (push && space && !flush) begin
        buf_mem[wp] <= wd;
      end
    end

    assign serial_out[ch] = r.pins;
    assign tx_space[ch]   = space;
  end

endmodule : dua_uart

//--- testbench/dua_props.sv
`timescale 1ns/1ps
module dua_props (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input dua_pkg::dua_bus_req_t          host_req,
  input wire logic [7:0]                host_rdata,
  input wire logic [1:0]                rx_pin,
  input dua_pkg::dua_modem_in_t [1:0]   modem_in,
  input dua_pkg::dua_serial_out_t [1:0] serial_out,
  input wire logic [1:0]                tx_space
);
  import dua_pkg::*;
  // ----------------------------------------
  // shadow of channel a registers
  // ----------------------------------------
  logic       prv_rd, prv_wr, rd_e, rb_e, wr_e, enh;
  logic [7:0] line_control, modem_control, scratch_pad, enhanced_function, wd;
  logic [2:0] a;
  assign a    = host_req.addr;
  assign wd   = host_req.wdata;
  assign rd_e = !host_req.read_n && prv_rd && !host_req.chip_select_a_n;
  assign rb_e = !host_req.read_n && prv_rd && !host_req.chip_select_b_n;
  assign wr_e = !host_req.write_n && prv_wr && !host_req.chip_select_a_n;
  assign enh  = line_control == ENH_PAGE;
  // strobes start high so a strobe held low at release is an edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {prv_rd, prv_wr}     <= 2'b11;
      {line_control, modem_control, scratch_pad, enhanced_function} <= '0;
    end else begin
      prv_rd <= host_req.read_n;
      prv_wr <= host_req.write_n;
      if (wr_e && a == A_LCTL) line_control <= wd;
      if (wr_e && a == A_MCTL && !enh) modem_control <= enhanced_function[EF_ENH] ? wd : {modem_control[7:5], wd[4:0]};
      if (wr_e && a == A_SCR && !enh) scratch_pad <= wd;
      if (wr_e && a == A_EFUNC && enh) enhanced_function <= wd;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_hold; !(rd_e || rb_e) |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_lcr; rd_e && a == A_LCTL |=> host_rdata == line_control; endproperty
  a_lcr: assert property (p_lcr) else $error("line control readback wrong");
  property p_spr; rd_e && a == A_SCR && !enh |=> host_rdata == scratch_pad; endproperty
  a_spr: assert property (p_spr) else $error("scratch readback wrong");
  property p_mcr;
    rd_e && a == A_MCTL && !enh |=> host_rdata == (enhanced_function[EF_ENH] ? modem_control : modem_control & 8'h1f);
  endproperty
  a_mcr: assert property (p_mcr) else $error("modem control mask wrong");
  property p_efr; rd_e && a == A_EFUNC && enh |=> host_rdata == enhanced_function; endproperty
  a_efr: assert property (p_efr) else $error("enhanced function readback wrong");
  property p_lpin; modem_control[MC_LOOP] && $stable(modem_control) |-> serial_out[0] == 3'b111; endproperty
  a_lpin: assert property (p_lpin) else $error("pins not held in loopback");
  property p_lmsr;
    rd_e && a == A_MSTS && !enh && modem_control[MC_LOOP]
      |=> host_rdata[7:4] == {modem_control[MC_OP2], modem_control[MC_OP1], modem_control[MC_DTR], modem_control[MC_RTS]};
  endproperty
  a_lmsr: assert property (p_lmsr) else $error("loopback modem status wrong");
  property p_ctl;
    !modem_control[MC_LOOP] && $stable(modem_control)
      |-> serial_out[0].dtr_n == !modem_control[MC_DTR] && serial_out[0].rts_n == !modem_control[MC_RTS];
  endproperty
  a_ctl: assert property (p_ctl) else $error("dtr or rts pin wrong");
endmodule : dua_props

//--- testbench/dua_line_model.sv
`timescale 1ns/1ps
module dua_line_model (
  input dua_pkg::dua_serial_out_t [1:0] serial_out,
  input wire logic                      ext_loop,
  input wire logic [3:0]                mdm_lvl,
  output logic [1:0]                    rx_pin,
  output dua_pkg::dua_modem_in_t [1:0]  modem_in
);
  import dua_pkg::*;
  // ----------------------------------------
  // far end: cable loop or marking line
  // ----------------------------------------
  // marking keeps a false break from showing after loopback ends
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      rx_pin[i]   = ext_loop ? serial_out[i].txd : 1'b1;
      modem_in[i] = mdm_lvl;
    end
  end
endmodule : dua_line_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dua_pkg::*;
  // ----------------------------------------
  // clock, reset and block under test
  // ----------------------------------------
  logic                  mclk     = 1'b0;
  logic                  rst_n    = 1'b0;
  logic                  ext_loop = 1'b0;
  logic [3:0]            mdm_lvl  = 4'h5;
  logic [7:0]            rdata, q;
  logic [1:0]            rx_pin, tx_space;
  logic [2:0]            pg [5] = '{A_EFUNC, A_RES1, A_RES2, A_PAU1, A_PAU2};
  dua_bus_req_t          req      = '1;
  dua_modem_in_t [1:0]   modem_in;
  dua_serial_out_t [1:0] serial_out;
  int                    n_errors = 0;
  int                    total_checks = 0;
  int                    n;
  always #25 mclk = ~mclk;
  dua_uart i_dut (.mclk(mclk), .rst_n(rst_n), .host_req(req), .host_rdata(rdata),
    .rx_pin(rx_pin), .modem_in(modem_in), .serial_out(serial_out), .tx_space(tx_space));
  dua_line_model i_line (.serial_out(serial_out), .ext_loop(ext_loop), .mdm_lvl(mdm_lvl),
    .rx_pin(rx_pin), .modem_in(modem_in));
  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one strobe edge per access, strobe high a full cycle after
  task acc(input logic ch, input logic rd, input logic [2:0] ad, input logic [7:0] d);
    req = '{ch, !ch, !rd, rd, ad, d};
    @(posedge mclk);
    #1;
    q   = rdata;
    req = '1;
    @(posedge mclk);
    #1;
  endtask : acc
  task w(input logic ch, input logic [2:0] ad, input logic [7:0] d);
    acc(ch, 1'b0, ad, d);
  endtask : w
  task r(input logic ch, input logic [2:0] ad, input logic [7:0] exp);
    acc(ch, 1'b1, ad, 8'h00);
    chk(q, exp);
  endtask : r
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    w(0, A_LCTL, 8'h1b);
    w(1, A_LCTL, 8'h07);
    r(0, A_LCTL, 8'h1b);
    r(1, A_LCTL, 8'h07);
    w(0, A_SCR, 8'h3c);
    r(0, A_SCR, 8'h3c);
    w(0, A_IENA, 8'hf2);
    r(0, A_IENA, 8'h02);
    w(0, A_ISTS, 8'h31);
    r(0, A_ISTS, 8'hc2);
    $display("regs done");
  endtask : t_regs
  task t_pages;
    w(0, A_LCTL, 8'h80);
    r(0, A_DIV_LO, 8'h01);
    r(0, A_DIV_HI, 8'h5a);
    w(0, A_DIV_LO, 8'h01);
    r(0, A_DIV_LO, 8'h01);
    w(0, A_LCTL, ENH_PAGE);
    for (int i = 0; i < 5; i++) w(0, pg[i], 8'h10 + i);
    for (int i = 0; i < 5; i++) r(0, pg[i], 8'h10 + i);
    w(0, A_LCTL, 8'h80);
    w(0, A_DIV_FR, 8'hff);
    r(0, A_DIV_FR, DLD_MASK);
    w(0, A_LCTL, 8'h03);
    w(0, A_IENA, 8'hf2);
    r(0, A_IENA, 8'hf2);
    $display("pages done");
  endtask : t_pages
  task t_loop;
    w(0, A_MCTL, 8'h1e);
    mdm_lvl = 4'ha;
    chk({5'h0, serial_out[0]}, 8'h07);
    acc(0, 1'b1, A_MSTS, 8'h00);
    chk(q & 8'hf0, 8'hd0);
    w(0, A_DATA, 8'ha5);
    n = 0;
    do begin
      acc(0, 1'b1, A_LSTS, 8'h00);
      n++;
    end while (q[0] !== 1'b1 && n < 400);
    r(0, A_DATA, 8'ha5);
    w(0, A_MCTL, 8'h03);
    chk({5'h0, serial_out[0]}, 8'h04);
    $display("loopback done");
  endtask : t_loop
  // two-entry buffer fills behind a busy shifter, then frees a slot
  task t_buf;
    ext_loop = 1'b1;
    for (int i = 0; i < 3; i++) w(0, A_DATA, 8'h40 + i);
    chk({6'h0, tx_space}, 8'h02);
    n = 0;
    while (tx_space[0] !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, tx_space[0]}, 8'h01);
    $display("buffer done");
  endtask : t_buf
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_pages();
    t_loop();
    t_buf();
    end_of_test();
  end
  // a few hundred cycles expected; cut off well beyond
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
endmodule : testbench
bind dua_uart dua_props i_props (.mclk(mclk), .rst_n(rst_n), .host_req(host_req),
  .host_rdata(host_rdata), .rx_pin(rx_pin), .modem_in(modem_in),
  .serial_out(serial_out), .tx_space(tx_space));
